// [slc_pkg.sv]
package slc_pkg;

  localparam logic [7:0] ADDR_CTRL_A = 8'hE4;
  localparam logic [7:0] ADDR_CTRL_B = 8'hE5;
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  localparam int SEG_MAX = 40;
  localparam int COM_MAX = 4;
  localparam int DISP_BITS = SEG_MAX * COM_MAX;

  // prescaled lcd clock edges per frame
  localparam int FRAME_CNT_W = 8;
  localparam logic [FRAME_CNT_W-1:0] FRAME_TICKS = 8'h10;

  localparam logic [1:0] DUTY_STATIC = 2'h0;
  localparam logic [1:0] DUTY_HALF = 2'h1;
  localparam logic [1:0] DUTY_THIRD = 2'h2;
  localparam logic [1:0] DUTY_QUARTER = 2'h3;

  localparam logic [1:0] BIAS_STATIC = 2'h0;
  localparam logic [1:0] BIAS_THIRD = 2'h1;
  localparam logic [1:0] BIAS_HALF = 2'h2;

  localparam logic [3:0] MASK_SMALL_MAX = 4'h7;

  typedef logic [5:0] slc_segcnt_t;
  typedef logic [2:0] slc_comcnt_t;

  localparam slc_segcnt_t SEG_COUNT_TBL [16] = '{
    6'h0D, 6'h0F, 6'h11, 6'h13, 6'h15, 6'h17, 6'h18, 6'h19,
    6'h1B, 6'h1D, 6'h1F, 6'h21, 6'h23, 6'h25, 6'h27, 6'h28
  };

  localparam slc_comcnt_t COM_COUNT_TBL [4] = '{3'h1, 3'h2, 3'h3, 3'h4};

  typedef struct packed {
    logic enable;
    logic low_power;
    logic reserved;
    logic flag;
    logic irq_enable;
    logic buffer_disable;
    logic supply_disable;
    logic blanking;
  } slc_ctrl_a_s;

  typedef struct packed {
    logic async_select;
    logic half_bias;
    logic [1:0] duty;
    logic [3:0] port_mask;
  } slc_ctrl_b_s;

  // settings that only change at a frame boundary, or clear when the controller is disabled
  typedef struct packed {
    logic low_power;
    logic blanking;
  } slc_frame_s;

endpackage

// [slc_sync2.sv]
`timescale 1ns/1ps
module slc_sync2 (
  input wire logic clk,
  input wire logic nrst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// [slc_frame_timer.sv]
`timescale 1ns/1ps
module slc_frame_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic tick,
  output logic frame_start
);

  logic [slc_pkg::FRAME_CNT_W-1:0] cnt_ff;
  logic [slc_pkg::FRAME_CNT_W-1:0] nxt_cnt;
  logic last_tick;

  assign last_tick = tick && (cnt_ff == slc_pkg::FRAME_TICKS - 8'h01);
  assign frame_start = run && last_tick;

  // stopped controller restarts a full frame from zero
  assign nxt_cnt = !run ? '0 :
                   last_tick ? '0 :
                   tick ? cnt_ff + 8'h01 : cnt_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// [slc_control.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - enable starts controller; clearing stops it at once and frees pins
// - waveform select change takes effect at next frame start
// - frame flag set at frame start, same cycle display data latched
// - flag cleared by vector taken or writing one; zero leaves it
// - interrupt request only when flag, enable and global enable set
// - low-power waveform sets the flag only every second frame
// - buffer disable bypasses bias buffers, divider drives levels
// - supply disable turns internal supply generator off
// - blanking grounds all terminals after current frame finishes
// - bit 5 of control register a reads zero
// - clock select picks system or async clock, async picked by pin
// - half bias select chooses half or third bias; static is static
// - duty field selects one to four commons; unused commons freed
// - port mask code gives 13 up to 40 active segments
// - segments beyond the mask stay ordinary port pins
// - small variant: mask msb reserved, reads zero
// - display data, blanking and waveform latched only at frame start
// - low-power waveform holds one pattern for two frames
// - blanking leaves display memory untouched
module slc_control #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic irq_global_enable,
  input wire logic irq_vector_taken,
  output logic irq_request,
  input wire logic timer_oscillator_input,
  input wire logic external_clock_in,
  input wire logic external_clock_input_enable,
  input wire logic [slc_pkg::DISP_BITS-1:0] display_memory_in,
  output logic [slc_pkg::DISP_BITS-1:0] frame_pattern,
  output logic frame_start_pulse,
  output logic [slc_pkg::SEG_MAX-1:0] segment_terminals_owned,
  output logic [slc_pkg::COM_MAX-1:0] common_terminals_owned,
  output logic terminals_grounded,
  output logic low_power_waveform_active,
  output logic [1:0] bias_mode,
  output logic [1:0] duty_active,
  output logic bias_buffer_bypass,
  output logic supply_generator_off
);

  slc_pkg::slc_ctrl_a_s ctrl_a_ff;
  slc_pkg::slc_ctrl_a_s nxt_ctrl_a;
  slc_pkg::slc_ctrl_b_s ctrl_b_ff;
  slc_pkg::slc_ctrl_b_s nxt_ctrl_b;
  slc_pkg::slc_ctrl_a_s wr_a;
  slc_pkg::slc_ctrl_b_s wr_b;
  slc_pkg::slc_frame_s frame_ff;
  slc_pkg::slc_frame_s nxt_frame;

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [slc_pkg::DISP_BITS-1:0] pattern_ff;
  logic [slc_pkg::DISP_BITS-1:0] nxt_pattern;
  logic pair_second_ff;
  logic nxt_pair_second;
  logic async_prev_ff;
  logic flag_ff;
  logic nxt_flag;

  logic [slc_pkg::SEG_MAX-1:0] seg_own_ff;
  logic [slc_pkg::SEG_MAX-1:0] nxt_seg_own;
  logic [slc_pkg::COM_MAX-1:0] com_own_ff;
  logic [slc_pkg::COM_MAX-1:0] nxt_com_own;
  logic ground_ff;
  logic nxt_ground;
  logic lp_out_ff;
  logic [1:0] bias_ff;
  logic [1:0] nxt_bias;
  logic [1:0] duty_ff;
  logic bypass_ff;
  logic supply_off_ff;
  logic nxt_lp_out;
  logic nxt_bypass;
  logic nxt_supply_off;

  // ---------------- register bus decode
  wire sel_a = (bus_addr == slc_pkg::ADDR_CTRL_A);
  wire sel_b = (bus_addr == slc_pkg::ADDR_CTRL_B);
  wire wr_a_hit = bus_wr && sel_a;
  wire wr_b_hit = bus_wr && sel_b;
  wire rd_a_hit = bus_rd && sel_a;
  wire rd_b_hit = bus_rd && sel_b;

  assign wr_a = slc_pkg::slc_ctrl_a_s'(bus_wdata);
  assign wr_b = slc_pkg::slc_ctrl_b_s'(bus_wdata);

  // ---------------- frame timing source
  wire async_raw = external_clock_input_enable ? external_clock_in
                                               : timer_oscillator_input;
  wire async_sync;

  slc_sync2 u_async_sync (
    .clk(clk),
    .nrst(nrst),
    .async_in(async_raw),
    .sync_out(async_sync)
  );

  wire async_edge = async_sync && !async_prev_ff;
  // system clock ticks every cycle, async source on each synced rising edge
  wire lcd_tick = ctrl_b_ff.async_select ? async_edge : 1'b1;

  wire frame_raw;

  slc_frame_timer u_frame_timer (
    .clk(clk),
    .nrst(nrst),
    .run(ctrl_a_ff.enable),
    .tick(lcd_tick),
    .frame_start(frame_raw)
  );

  // in low-power mode the second frame of a pair reuses the pattern
  wire frame_latch = frame_raw && !pair_second_ff;

  // ---------------- frame boundary latching
  always_comb begin
    nxt_frame = frame_ff;
    nxt_pattern = pattern_ff;
    nxt_pair_second = pair_second_ff;
    if (frame_latch) begin
      nxt_frame.low_power = ctrl_a_ff.low_power;
      nxt_frame.blanking = ctrl_a_ff.blanking;
      nxt_pattern = display_memory_in;
      nxt_pair_second = ctrl_a_ff.low_power;
    end else if (frame_raw) begin
      nxt_pair_second = 1'b0;
    end
    // stale latched settings must not reappear on re-enable
    if (!ctrl_a_ff.enable) begin
      nxt_frame = '0;
      nxt_pair_second = 1'b0;
    end
  end

  // ---------------- frame flag: set wins over clear
  wire flag_clear = (wr_a_hit && wr_a.flag) || irq_vector_taken;
  assign nxt_flag = frame_latch ? 1'b1 : (flag_clear ? 1'b0 : flag_ff);

  // ---------------- control register next values
  always_comb begin
    nxt_ctrl_a = ctrl_a_ff;
    nxt_ctrl_b = ctrl_b_ff;
    if (wr_a_hit) begin
      nxt_ctrl_a = wr_a;
    end
    nxt_ctrl_a.reserved = 1'b0;
    nxt_ctrl_a.flag = nxt_flag;
    if (wr_b_hit) begin
      nxt_ctrl_b = wr_b;
      if (!LARGE_VARIANT) begin
        nxt_ctrl_b.port_mask = wr_b.port_mask & slc_pkg::MASK_SMALL_MAX;
      end
    end
  end

  // ---------------- read data, one cycle after the strobe
  wire [7:0] read_sel = rd_a_hit ? 8'(ctrl_a_ff) :
                        rd_b_hit ? 8'(ctrl_b_ff) :
                        slc_pkg::READ_UNMAPPED;
  assign nxt_rdata = bus_rd ? read_sel : slc_pkg::READ_UNMAPPED;

  // ---------------- pin ownership and drive configuration
  wire [5:0] seg_count = slc_pkg::SEG_COUNT_TBL[ctrl_b_ff.port_mask];
  wire [2:0] com_count = slc_pkg::COM_COUNT_TBL[ctrl_b_ff.duty];

  genvar gs;
  generate
    for (gs = 0; gs < slc_pkg::SEG_MAX; gs++) begin : g_seg
      assign nxt_seg_own[gs] = ctrl_a_ff.enable && (6'(gs) < seg_count);
    end
  endgenerate

  genvar gc;
  generate
    for (gc = 0; gc < slc_pkg::COM_MAX; gc++) begin : g_com
      assign nxt_com_own[gc] = ctrl_a_ff.enable && (3'(gc) < com_count);
    end
  endgenerate

  wire duty_static = (ctrl_b_ff.duty == slc_pkg::DUTY_STATIC);
  assign nxt_bias = duty_static ? slc_pkg::BIAS_STATIC :
                    ctrl_b_ff.half_bias ? slc_pkg::BIAS_HALF :
                    slc_pkg::BIAS_THIRD;
  // blanking in effect only once latched at a frame boundary
  assign nxt_ground = ctrl_a_ff.enable && nxt_frame.blanking;
  assign nxt_lp_out = ctrl_a_ff.enable && nxt_frame.low_power;
  assign nxt_bypass = ctrl_a_ff.enable && ctrl_a_ff.buffer_disable;
  assign nxt_supply_off = ctrl_a_ff.supply_disable;

  // ---------------- state registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_a_ff <= slc_pkg::slc_ctrl_a_s'(slc_pkg::CTRL_A_RST);
    end else begin
      ctrl_a_ff <= nxt_ctrl_a;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_b_ff <= slc_pkg::slc_ctrl_b_s'(slc_pkg::CTRL_B_RST);
    end else begin
      ctrl_b_ff <= nxt_ctrl_b;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= slc_pkg::READ_UNMAPPED;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      async_prev_ff <= 1'b0;
    end else begin
      async_prev_ff <= async_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      frame_ff <= '0;
    end else begin
      frame_ff <= nxt_frame;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pattern_ff <= '0;
    end else begin
      pattern_ff <= nxt_pattern;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pair_second_ff <= 1'b0;
    end else begin
      pair_second_ff <= nxt_pair_second;
    end
  end

  // ---------------- output registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      seg_own_ff <= '0;
    end else begin
      seg_own_ff <= nxt_seg_own;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      com_own_ff <= '0;
    end else begin
      com_own_ff <= nxt_com_own;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ground_ff <= 1'b0;
    end else begin
      ground_ff <= nxt_ground;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lp_out_ff <= 1'b0;
    end else begin
      lp_out_ff <= nxt_lp_out;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bias_ff <= slc_pkg::BIAS_STATIC;
    end else begin
      bias_ff <= nxt_bias;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      duty_ff <= slc_pkg::DUTY_STATIC;
    end else begin
      duty_ff <= ctrl_b_ff.duty;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bypass_ff <= 1'b0;
    end else begin
      bypass_ff <= nxt_bypass;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      supply_off_ff <= 1'b0;
    end else begin
      supply_off_ff <= nxt_supply_off;
    end
  end

  assign bus_rdata = rdata_ff;
  assign irq_request = flag_ff && ctrl_a_ff.irq_enable && irq_global_enable;
  assign frame_pattern = pattern_ff;
  assign frame_start_pulse = frame_latch;
  assign segment_terminals_owned = seg_own_ff;
  assign common_terminals_owned = com_own_ff;
  assign terminals_grounded = ground_ff;
  assign low_power_waveform_active = lp_out_ff;
  assign bias_mode = bias_ff;
  assign duty_active = duty_ff;
  assign bias_buffer_bypass = bypass_ff;
  assign supply_generator_off = supply_off_ff;

endmodule

// [slc_checker.sv]
`timescale 1ns/1ps
module slc_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic irq_global_enable,
  input wire logic irq_request,
  input wire logic [slc_pkg::DISP_BITS-1:0] display_memory_in,
  input wire logic [slc_pkg::DISP_BITS-1:0] frame_pattern,
  input wire logic frame_start_pulse,
  input wire logic [slc_pkg::SEG_MAX-1:0] segment_terminals_owned,
  input wire logic terminals_grounded,
  input wire logic low_power_waveform_active,
  input wire logic [1:0] bias_mode,
  input wire logic [1:0] duty_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_irq_needs_global: assert property (
    irq_request |-> irq_global_enable) else $error("irq without global");
  a_pattern_load: assert property (
    frame_start_pulse |=> frame_pattern == $past(display_memory_in)) else $error("no load");
  a_pattern_hold: assert property (
    !frame_start_pulse |=> $stable(frame_pattern)) else $error("pattern moved");
  a_waveform_at_frame: assert property (
    $rose(low_power_waveform_active) |-> $past(frame_start_pulse)) else $error("lp early");
  a_blank_at_frame: assert property (
    $rose(terminals_grounded) |-> $past(frame_start_pulse)) else $error("blank early");
  a_frame_spacing: assert property (
    frame_start_pulse |=> !frame_start_pulse [*8]) else $error("frames too close");
  a_seg_contiguous: assert property (
    (segment_terminals_owned & (segment_terminals_owned + 1'b1)) == '0)
    else $error("segment gap");
  a_seg_minimum: assert property (
    |segment_terminals_owned |-> &segment_terminals_owned[12:0]) else $error("few segments");
  a_static_bias: assert property (
    duty_active == slc_pkg::DUTY_STATIC |-> bias_mode == slc_pkg::BIAS_STATIC)
    else $error("static bias");
endmodule

bind slc_control slc_checker slc_checker_i (.clk(clk), .nrst(nrst),
  .irq_global_enable(irq_global_enable), .irq_request(irq_request),
  .display_memory_in(display_memory_in), .frame_pattern(frame_pattern),
  .frame_start_pulse(frame_start_pulse), .segment_terminals_owned(segment_terminals_owned),
  .terminals_grounded(terminals_grounded),
  .low_power_waveform_active(low_power_waveform_active),
  .bias_mode(bias_mode), .duty_active(duty_active));

// [slc_glass_model.sv]
`timescale 1ns/1ps
module slc_glass_model (
  input wire logic run,
  output logic xtal,
  output logic ext_clk
);
  // crystal and external sources, frozen while run is low
  initial begin
    xtal = 1'b0;
    ext_clk = 1'b0;
  end
  always #170 if (run === 1'b1) xtal = ~xtal;
  always #130 if (run === 1'b1) ext_clk = ~ext_clk;
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] RA = slc_pkg::ADDR_CTRL_A;
  localparam logic [7:0] RB = slc_pkg::ADDR_CTRL_B;
  logic clk, nrst, wr_s, rd_s, rd_d, gie, vec, run, xt, xc, xen, fsp, irq, gnd, lpa, bbp, sgo;
  logic [7:0] addr, wd, rdat;
  logic [159:0] dm, pat;
  logic [39:0] seg;
  logic [3:0] com;
  logic [1:0] bias, duty;
  logic [7:0] q[$];
  int fail_count, comparisons, n;
  int tbl[16] = '{13, 15, 17, 19, 21, 23, 24, 25, 27, 29, 31, 33, 35, 37, 39, 40};
  slc_control slc_control_i (.clk(clk), .nrst(nrst), .bus_addr(addr), .bus_wdata(wd),
    .bus_wr(wr_s), .bus_rd(rd_s), .bus_rdata(rdat), .irq_global_enable(gie),
    .irq_vector_taken(vec), .irq_request(irq), .timer_oscillator_input(xt),
    .external_clock_in(xc), .external_clock_input_enable(xen), .display_memory_in(dm),
    .frame_pattern(pat), .frame_start_pulse(fsp), .segment_terminals_owned(seg),
    .common_terminals_owned(com), .terminals_grounded(gnd), .low_power_waveform_active(lpa),
    .bias_mode(bias), .duty_active(duty), .bias_buffer_bypass(bbp),
    .supply_generator_off(sgo));
  slc_glass_model slc_glass_model_i (.run(run), .xtal(xt), .ext_clk(xc));
  task automatic chk(input string s, input logic [159:0] e, input logic [159:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %0h got %0h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
  endtask
  // waits for a frame start, returns on the edge that sets the flag
  task automatic frame(output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (fsp !== 1'b1 && c < 400);
    @(posedge clk);
  endtask
  task automatic rnd();
    for (int i = 0; i < 5; i++) dm[i*32 +: 32] <= $urandom;
  endtask
  task automatic results();
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    rd_d <= rd_s;
    if (rd_d === 1'b1) chk("rdata", q.pop_front(), rdat);
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end
  initial begin
    void'($urandom(44776));
    {nrst, wr_s, rd_s, gie, vec, run, xen, addr, wd, dm} = '0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rnd();
    @(posedge clk);
    rd(RA, 8'h00);
    rd(RB, 8'h00);
    wr(8'hE6, 8'hFF);
    rd(8'hE6, 8'h00);
    rd(RA, 8'h00);
    wr(RA, 8'h7F);
    rd(RA, 8'h4F);
    chk("bypass", 1'b0, bbp);
    chk("supply", 1'b1, sgo);
    wr(RA, 8'h86);
    for (int i = 0; i < 16; i++) begin
      wr(RB, {1'b0, i[0], i[1:0], i[3:0]});
      rd(RB, {1'b0, i[0], i[1:0], i[3:0]});
      chk("seg", (40'h1 << tbl[i]) - 40'h1, seg);
      chk("com", (4'h2 << i[1:0]) - 4'h1, com);
      chk("duty", i[1:0], duty);
      chk("bias", i[1:0] == 2'h0 ? 2'h0 : (i[0] ? 2'h2 : 2'h1), bias);
    end
    chk("bypass", 1'b1, bbp);
    gie <= 1'b1;
    rnd();
    wr(RA, 8'h9A);
    frame(n);
    @(negedge clk);
    chk("irq", 1'b1, irq);
    chk("pattern", dm, pat);
    @(posedge clk);
    vec <= 1'b1;
    @(posedge clk);
    vec <= 1'b0;
    rd(RA, 8'h8A);
    gie <= 1'b0;
    frame(n);
    frame(n);
    chk("gap", slc_pkg::FRAME_TICKS, n);
    rd(RA, 8'h9A);
    chk("irq", 1'b0, irq);
    wr(RA, 8'h8A);
    rd(RA, 8'h9A);
    wr(RA, 8'h9A);
    rd(RA, 8'h8A);
    wr(RA, 8'hCA);
    frame(n);
    frame(n);
    frame(n);
    @(negedge clk);
    chk("lp", 1'b1, lpa);
    chk("lpgap", 2 * slc_pkg::FRAME_TICKS, n);
    @(posedge clk);
    wr(RA, 8'h9B);
    frame(n);
    @(negedge clk);
    chk("blank", 1'b1, gnd);
    chk("keep", dm, pat);
    @(posedge clk);
    wr(RA, 8'h00);
    @(negedge clk);
    chk("segoff", 40'h0, seg);
    chk("comoff", 4'h0, com);
    @(posedge clk);
    run <= 1'b1;
    wr(RB, 8'hBF);
    wr(RA, 8'h82);
    frame(n);
    chk("xtal", 1'b1, n > 40 && n < 400);
    xen <= 1'b1;
    frame(n);
    frame(n);
    chk("ext", 1'b1, n > 40 && n < 400);
    results();
  end
endmodule
